// >>> inc/fan_curve_pkg.sv
// Constants, register map and carrier types for the fan speed curve block.
// Assumes a single 100 MHz clock domain and a 32-bit APB register port.
package fan_curve_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CURVE0 = 12'h000;
  localparam logic [11:0] OFS_CURVE1 = 12'h004;
  localparam logic [11:0] OFS_CURVE2 = 12'h008;
  localparam logic [11:0] OFS_SLOPE1 = 12'h00C;
  localparam logic [11:0] OFS_SLOPE2 = 12'h010;
  localparam logic [11:0] OFS_PULSE = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;

  // Field positions
  localparam int POS_STOP = 8;
  localparam int POS_NEVER_HALT = 15;
  localparam int POS_CHANGE = 8;
  localparam int POS_STARTUP = 4;
  localparam int POS_SLOPE = 2;
  localparam int POS_OPEN_ON_CLAMP = 1;
  localparam int POS_FULL_ON = 0;
  localparam int POS_LOOP_SEL = 0;
  localparam int POS_LOCK_EN = 3;
  localparam int POS_ST_RUN = 18;
  localparam int POS_ST_OVR = 19;
  localparam int POS_ST_SLOW = 20;
  localparam int POS_ST_OPEN = 21;

  // Curve arithmetic
  localparam logic [9:0] CLAMP_BASE = 10'h101;
  localparam logic [17:0] DUTY_FULL = 18'h00200;
  localparam int CL_SHIFT = 6;
  localparam int OL_SHIFT = 10;

  // Pulse rate select codes
  localparam logic [2:0] RATE_1 = 3'h0;
  localparam logic [2:0] RATE_2_3 = 3'h1;
  localparam logic [2:0] RATE_1_2 = 3'h2;
  localparam logic [2:0] RATE_2 = 3'h3;
  localparam logic [2:0] RATE_3 = 3'h4;
  localparam logic [2:0] RATE_12_5 = 3'h5;
  localparam logic [2:0] RATE_1_3 = 3'h6;

  // Timing: lowest hall frequency in mHz, clock rate, derived longest period
  localparam longint CLK_HZ = 100000000;
  localparam longint HALL_MIN_MHZ = 1670;
  localparam int SLOW_CYC = int'((CLK_HZ * 1000) / HALL_MIN_MHZ);

  // Software configuration carrier
  typedef struct packed {
    logic [7:0] start_threshold;
    logic [6:0] stop_threshold;
    logic never_halt;
    logic [7:0] clamp_threshold;
    logic [7:0] change_point;
    logic [3:0] clamp_hysteresis;
    logic [11:0] startup_speed;
    logic [13:0] first_slope;
    logic open_loop_on_clamp;
    logic full_on_at_low_command;
    logic [13:0] second_slope;
    logic loop_select;
    logic [2:0] pulse_rate_select;
    logic lock_signal_en;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;

endpackage : fan_curve_pkg

// >>> logic/fan_speed_curve.sv
// Speed command to target mapping and open-drain rotation pulse output.
// Assumes speed command and lock flag come from logic on clk_i; hall is a pin.
`timescale 1ns/1ps

module fan_speed_curve #(
  parameter int CNT_W = 26,
  parameter int SLOW_CYC = fan_curve_pkg::SLOW_CYC,
  parameter int TGT_W = 18
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic [8:0] speed_command_in_i, // Resolved 9-bit command
  input wire logic hall_i, // Hall pin, asynchronous
  input wire logic lock_detect_i, // Motor lock detected
  output logic [TGT_W-1:0] target_o, // Target rpm or duty count
  output logic open_loop_o, // Target is a duty
  output logic motor_en_o, // Motor output enabled
  output logic rotation_pulse_out_o, // Open-drain data, always low
  output logic rotation_pulse_out_oe_o // High pulls pin low
);

  fan_curve_pkg::cfg_t cfg_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata_nxt;
  logic map_hit;
  logic run_r;
  logic ovr_r;
  logic [TGT_W-1:0] target_r;
  logic [TGT_W-1:0] target_nxt;
  logic open_nxt;
  logic open_r;
  logic en_r;
  logic [9:0] cmd;
  logic [9:0] start_pt;
  logic [9:0] stop_pt;
  logic [9:0] clamp_pt;
  logic [9:0] change_pt;
  logic [9:0] hys;
  logic hall_m;
  logic hall_s;
  logic hall_d;
  logic hall_rise;
  logic [CNT_W-1:0] per_cnt_r;
  logic [CNT_W-1:0] period_r;
  logic slow_r;
  logic [CNT_W+2:0] acc_r;
  logic [CNT_W+2:0] acc_sum;
  logic [CNT_W+2:0] thr;
  logic [3:0] rate_num;
  logic [2:0] rate_den;
  logic tog_r;
  logic level;
  logic oe_r;
  logic pin_r;

  // Product of slope and command span, scaled per loop type
  function automatic logic [TGT_W-1:0] seg(input logic [9:0] from, input logic [9:0] upto,
                                           input logic [13:0] slope, input logic open);
    logic [23:0] prod;
    prod = '0;
    if (upto > from) begin
      prod = slope * (upto - from);
    end
    seg = open ? TGT_W'(prod >> fan_curve_pkg::OL_SHIFT) : TGT_W'(prod >> fan_curve_pkg::CL_SHIFT);
  endfunction : seg

  // Curve value at a command position above the start point
  function automatic logic [TGT_W-1:0] curve(input fan_curve_pkg::cfg_t c, input logic [9:0] pt,
                                             input logic [9:0] st, input logic [9:0] chg,
                                             input logic open);
    logic [TGT_W-1:0] base;
    logic [TGT_W-1:0] val;
    base = open ? TGT_W'(c.startup_speed[11:4]) : TGT_W'(c.startup_speed);
    if (c.change_point != 8'h00 && pt > chg) begin
      val = base + seg(st, chg, c.first_slope, open) + seg(chg, pt, c.second_slope, open);
    end else begin
      val = base + seg(st, pt, c.first_slope, open);
    end
    if (open && val > fan_curve_pkg::DUTY_FULL) begin
      val = fan_curve_pkg::DUTY_FULL;
    end
    curve = val;
  endfunction : curve

  // Ratio of output pulses to hall cycles as numerator and denominator
  function automatic logic [6:0] rate_ratio(input logic [2:0] sel);
    unique case (sel)
      fan_curve_pkg::RATE_2_3: rate_ratio = {4'h2, 3'h3};
      fan_curve_pkg::RATE_1_2: rate_ratio = {4'h1, 3'h2};
      fan_curve_pkg::RATE_2: rate_ratio = {4'h2, 3'h1};
      fan_curve_pkg::RATE_3: rate_ratio = {4'h3, 3'h1};
      fan_curve_pkg::RATE_12_5: rate_ratio = {4'hC, 3'h5};
      fan_curve_pkg::RATE_1_3: rate_ratio = {4'h1, 3'h3};
      default: rate_ratio = {4'h1, 3'h1};
    endcase
  endfunction : rate_ratio

  // Command positions in the 512 full scale
  assign cmd = {1'b0, speed_command_in_i};
  assign start_pt = {2'h0, cfg_r.start_threshold};
  assign stop_pt = {2'h0, cfg_r.stop_threshold, 1'b0};
  assign clamp_pt = fan_curve_pkg::CLAMP_BASE + {2'h0, cfg_r.clamp_threshold};
  assign change_pt = {1'b0, cfg_r.change_point, 1'b0};
  assign hys = {4'h0, 5'({1'b0, cfg_r.clamp_hysteresis} + 5'h01), 1'b0};

  // APB address decode and read mux
  always_comb begin
    map_hit = 1'b1;
    rdata_nxt = 32'h00000000;
    unique case (paddr_i)
      fan_curve_pkg::OFS_CURVE0: begin
        rdata_nxt[7:0] = cfg_r.start_threshold;
        rdata_nxt[fan_curve_pkg::POS_STOP +: 7] = cfg_r.stop_threshold;
        rdata_nxt[fan_curve_pkg::POS_NEVER_HALT] = cfg_r.never_halt;
      end
      fan_curve_pkg::OFS_CURVE1: begin
        rdata_nxt[7:0] = cfg_r.clamp_threshold;
        rdata_nxt[fan_curve_pkg::POS_CHANGE +: 8] = cfg_r.change_point;
      end
      fan_curve_pkg::OFS_CURVE2: begin
        rdata_nxt[3:0] = cfg_r.clamp_hysteresis;
        rdata_nxt[fan_curve_pkg::POS_STARTUP +: 12] = cfg_r.startup_speed;
      end
      fan_curve_pkg::OFS_SLOPE1: begin
        rdata_nxt[fan_curve_pkg::POS_SLOPE +: 14] = cfg_r.first_slope;
        rdata_nxt[fan_curve_pkg::POS_OPEN_ON_CLAMP] = cfg_r.open_loop_on_clamp;
        rdata_nxt[fan_curve_pkg::POS_FULL_ON] = cfg_r.full_on_at_low_command;
      end
      fan_curve_pkg::OFS_SLOPE2: begin
        rdata_nxt[fan_curve_pkg::POS_SLOPE +: 14] = cfg_r.second_slope;
        rdata_nxt[fan_curve_pkg::POS_LOOP_SEL] = cfg_r.loop_select;
      end
      fan_curve_pkg::OFS_PULSE: begin
        rdata_nxt[2:0] = cfg_r.pulse_rate_select;
        rdata_nxt[fan_curve_pkg::POS_LOCK_EN] = cfg_r.lock_signal_en;
      end
      fan_curve_pkg::OFS_STATUS: begin
        rdata_nxt[TGT_W-1:0] = target_r;
        rdata_nxt[fan_curve_pkg::POS_ST_RUN] = run_r;
        rdata_nxt[fan_curve_pkg::POS_ST_OVR] = ovr_r;
        rdata_nxt[fan_curve_pkg::POS_ST_SLOW] = slow_r;
        rdata_nxt[fan_curve_pkg::POS_ST_OPEN] = open_r;
      end
      default: begin
        map_hit = 1'b0;
      end
    endcase
  end

  // APB handshake: answer in the first access cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel_i && !penable_i;
      pslverr_r <= psel_i && !penable_i && !map_hit;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_r <= rdata_nxt;
      end else if (!psel_i) begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  // Configuration writes on the completing access edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= fan_curve_pkg::CFG_RESET;
    end else if (psel_i && penable_i && pready_r && pwrite_i) begin
      unique case (paddr_i)
        fan_curve_pkg::OFS_CURVE0: begin
          cfg_r.start_threshold <= pwdata_i[7:0];
          cfg_r.stop_threshold <= pwdata_i[fan_curve_pkg::POS_STOP +: 7];
          cfg_r.never_halt <= pwdata_i[fan_curve_pkg::POS_NEVER_HALT];
        end
        fan_curve_pkg::OFS_CURVE1: begin
          cfg_r.clamp_threshold <= pwdata_i[7:0];
          cfg_r.change_point <= pwdata_i[fan_curve_pkg::POS_CHANGE +: 8];
        end
        fan_curve_pkg::OFS_CURVE2: begin
          cfg_r.clamp_hysteresis <= pwdata_i[3:0];
          cfg_r.startup_speed <= pwdata_i[fan_curve_pkg::POS_STARTUP +: 12];
        end
        fan_curve_pkg::OFS_SLOPE1: begin
          cfg_r.first_slope <= pwdata_i[fan_curve_pkg::POS_SLOPE +: 14];
          cfg_r.open_loop_on_clamp <= pwdata_i[fan_curve_pkg::POS_OPEN_ON_CLAMP];
          cfg_r.full_on_at_low_command <= pwdata_i[fan_curve_pkg::POS_FULL_ON];
        end
        fan_curve_pkg::OFS_SLOPE2: begin
          cfg_r.second_slope <= pwdata_i[fan_curve_pkg::POS_SLOPE +: 14];
          cfg_r.loop_select <= pwdata_i[fan_curve_pkg::POS_LOOP_SEL];
        end
        fan_curve_pkg::OFS_PULSE: begin
          cfg_r.pulse_rate_select <= pwdata_i[2:0];
          cfg_r.lock_signal_en <= pwdata_i[fan_curve_pkg::POS_LOCK_EN];
        end
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  // Run state: set above start, cleared at or below stop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r <= 1'b0;
    end else if (cmd > start_pt) begin
      run_r <= 1'b1;
    end else if (cmd <= stop_pt) begin
      run_r <= 1'b0;
    end
  end

  // Clamp override with release hysteresis
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_r <= 1'b0;
    end else if (!cfg_r.open_loop_on_clamp) begin
      ovr_r <= 1'b0;
    end else if (cmd > clamp_pt) begin
      ovr_r <= 1'b1;
    end else if (cmd + hys <= clamp_pt) begin
      ovr_r <= 1'b0;
    end
  end

  // Target selection over the whole command range
  always_comb begin
    logic full_on;
    logic [TGT_W-1:0] startup;
    logic [TGT_W-1:0] max_val;
    logic [TGT_W-1:0] full_val;
    full_on = cfg_r.full_on_at_low_command;
    startup = cfg_r.loop_select ? TGT_W'(cfg_r.startup_speed[11:4]) : TGT_W'(cfg_r.startup_speed);
    max_val = curve(cfg_r, clamp_pt, start_pt, change_pt, cfg_r.loop_select);
    full_val = cfg_r.open_loop_on_clamp ? fan_curve_pkg::DUTY_FULL : max_val;
    open_nxt = cfg_r.loop_select;
    target_nxt = '0;
    if (ovr_r || (cfg_r.open_loop_on_clamp && cmd > clamp_pt)) begin
      target_nxt = TGT_W'(cmd);
      open_nxt = 1'b1;
    end else if (cmd > clamp_pt) begin
      target_nxt = max_val;
    end else if (cmd > start_pt) begin
      target_nxt = curve(cfg_r, cmd, start_pt, change_pt, cfg_r.loop_select);
    end else if (cmd == 10'h000) begin
      if (full_on) begin
        target_nxt = full_val;
        open_nxt = cfg_r.loop_select || cfg_r.open_loop_on_clamp;
      end else if (cfg_r.never_halt) begin
        target_nxt = startup;
      end
    end else if (cmd <= stop_pt) begin
      if (cfg_r.never_halt && full_on) begin
        target_nxt = full_val;
        open_nxt = cfg_r.loop_select || cfg_r.open_loop_on_clamp;
      end else if (cfg_r.never_halt) begin
        target_nxt = startup;
      end
    end else begin
      if (cfg_r.never_halt || run_r) begin
        target_nxt = startup;
      end
    end
  end

  // Registered target, loop type and enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_r <= '0;
      open_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      target_r <= target_nxt;
      open_r <= open_nxt;
      en_r <= target_nxt != '0;
    end
  end

  // Hall synchroniser and edge detect
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hall_m <= 1'b0;
      hall_s <= 1'b0;
      hall_d <= 1'b0;
    end else begin
      hall_m <= hall_i;
      hall_s <= hall_m;
      hall_d <= hall_s;
    end
  end

  assign hall_rise = hall_s && !hall_d;

  // Hall period measurement and low-frequency detect
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_cnt_r <= '0;
      period_r <= CNT_W'(1);
      slow_r <= 1'b1;
    end else if (hall_rise) begin
      period_r <= per_cnt_r + CNT_W'(1);
      per_cnt_r <= '0;
      slow_r <= (per_cnt_r >= CNT_W'(SLOW_CYC));
    end else if (per_cnt_r >= CNT_W'(SLOW_CYC)) begin
      slow_r <= 1'b1;
    end else begin
      per_cnt_r <= per_cnt_r + CNT_W'(1);
    end
  end

  // Rate ratio and phase accumulator threshold
  assign {rate_num, rate_den} = rate_ratio(cfg_r.pulse_rate_select);
  assign thr = (CNT_W+3)'(rate_den) * (CNT_W+3)'(period_r);
  assign acc_sum = acc_r + (CNT_W+3)'({rate_num, 1'b0});

  // Synthesised pulse train: two toggles per output pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r <= '0;
      tog_r <= 1'b0;
    end else if (acc_sum >= thr) begin
      acc_r <= acc_sum - thr;
      tog_r <= !tog_r;
    end else begin
      acc_r <= acc_sum;
    end
  end

  assign level = (cfg_r.pulse_rate_select == fan_curve_pkg::RATE_1) ? hall_s : tog_r;

  // Open-drain pin drive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      pin_r <= 1'b0;
      if (cfg_r.lock_signal_en) begin
        oe_r <= lock_detect_i;
      end else if (slow_r) begin
        oe_r <= 1'b0;
      end else begin
        oe_r <= !level;
      end
    end
  end

  // Outputs
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign target_o = target_r;
  assign open_loop_o = open_r;
  assign motor_en_o = en_r;
  assign rotation_pulse_out_o = pin_r;
  assign rotation_pulse_out_oe_o = oe_r;

endmodule : fan_speed_curve

// >>> tb/fan_curve_assertions.sv
// Port checker for the fan speed curve block.
// Assumes it is bound to fan_speed_curve, one clock domain.
`timescale 1ns/1ps
module fan_curve_assertions #(
  parameter int SLOW_CYC = 2000,
  parameter int TGT_W = 18
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [31:0] prdata_o, // APB read data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic [8:0] speed_command_in_i, // Command
  input wire logic hall_i, // Hall pin
  input wire logic lock_detect_i, // Lock flag
  input wire logic [TGT_W-1:0] target_o, // Target
  input wire logic open_loop_o, // Target is a duty
  input wire logic motor_en_o, // Motor enable
  input wire logic rotation_pulse_out_o, // Pin data
  input wire logic rotation_pulse_out_oe_o // Pin pulled low
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] rate_r;
  logic lock_en_r;
  logic hall_d_r;
  logic [31:0] idle_r;
  // Shadow of the pulse register, taken at the write access edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_r <= 3'h0;
      lock_en_r <= 1'b0;
    end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == fan_curve_pkg::OFS_PULSE) begin
      rate_r <= pwdata_i[2:0];
      lock_en_r <= pwdata_i[fan_curve_pkg::POS_LOCK_EN];
    end
  end
  // Cycles since the last hall rise, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hall_d_r <= 1'b0;
      idle_r <= 32'h0;
    end else begin
      hall_d_r <= hall_i;
      if (hall_i && !hall_d_r) begin
        idle_r <= 32'h0;
      end else if (!idle_r[31]) begin
        idle_r <= idle_r + 32'h1;
      end
    end
  end
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_err_unmapped: assert property (psel_i && !penable_i && paddr_i > fan_curve_pkg::OFS_STATUS
    |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  a_no_err_mapped: assert property (psel_i && !penable_i && paddr_i[1:0] == 2'h0
    && paddr_i <= fan_curve_pkg::OFS_STATUS |=> !pslverr_o) else $error("mapped access refused");
  a_enable_tracks_target: assert property (motor_en_o == (target_o != '0))
    else $error("motor enable disagrees with target");
  a_pin_data_low: assert property (rotation_pulse_out_o == 1'b0)
    else $error("open drain data not low");
  a_lock_pulls_low: assert property (lock_en_r && lock_detect_i |=> rotation_pulse_out_oe_o)
    else $error("lock flag not driven low");
  a_lock_released: assert property (lock_en_r && !lock_detect_i |=> !rotation_pulse_out_oe_o)
    else $error("lock flag low without lock");
  a_hall_high_free: assert property ((!lock_en_r && rate_r == 3'h0 && hall_i)[*3]
    |=> !rotation_pulse_out_oe_o) else $error("pin low while hall high");
  a_slow_released: assert property ((!lock_en_r)[*2] ##0 (idle_r > SLOW_CYC + 8)
    |-> !rotation_pulse_out_oe_o) else $error("pin driven while hall slow");
  a_duty_cap: assert property (open_loop_o |-> target_o <= 18'h00200)
    else $error("duty above full scale");
  cover property (open_loop_o && target_o == 18'h00200);
  cover property (pslverr_o);
  cover property (lock_en_r && lock_detect_i);
endmodule : fan_curve_assertions

// >>> tb/fan_env_model.sv
// Model of the command source and hall sensor facing the block.
// Assumes the bench sets the command level and the hall half period.
`timescale 1ns/1ps
module fan_env_model (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic run_i, // Motor turning
  input wire logic [15:0] half_i, // Hall half period in cycles
  input wire logic [8:0] cmd_i, // Requested command
  output logic [8:0] speed_command_in_o, // Resolved command count
  output logic hall_o // Hall sensor level
);
  logic [15:0] cnt_r;
  // Resolved command, copied from cmd_i each clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_command_in_o <= 9'h000;
    end else begin
      speed_command_in_o <= cmd_i;
    end
  end
  // Hall square wave, still and low while stopped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 16'h0000;
      hall_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= 16'h0000;
      hall_o <= 1'b0;
    end else if (cnt_r + 16'h0001 >= half_i) begin
      cnt_r <= 16'h0000;
      hall_o <= ~hall_o;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule : fan_env_model

// >>> tb/testbench.sv
// Self-checking bench for the fan speed curve block.
// Assumes zero wait state APB and the partner model on command and hall.
`timescale 1ns/1ps
module testbench;
  localparam int SLOW = 2000;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, open_loop_o, motor_en_o, pin_o, pin_oe, err, prev;
  logic [17:0] target_o;
  logic [8:0] cmd_set = 9'h000, cmd;
  logic run = 1'b0, hall, lock_det = 1'b0;
  int num_errors = 0, samples_checked = 0, n;
  int tog[7] = '{0, 20, 15, 60, 90, 72, 10};
  fan_speed_curve #(.SLOW_CYC(SLOW)) u_fan_speed_curve (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .speed_command_in_i(cmd), .hall_i(hall), .lock_detect_i(lock_det), .target_o(target_o),
    .open_loop_o(open_loop_o), .motor_en_o(motor_en_o), .rotation_pulse_out_o(pin_o),
    .rotation_pulse_out_oe_o(pin_oe));
  fan_env_model u_fan_env_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run),
    .half_i(16'h00C8), .cmd_i(cmd_set), .speed_command_in_o(cmd), .hall_o(hall));
  // Clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Count one comparison and report a mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One APB transfer, held until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      k++;
      if (k > 20) begin
        num_errors++;
        $display("unexpected at %0t: ready timeout got %h expected %h", $time, pready_o, 1'b1);
        stop_test();
      end
      @(posedge clk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Apply a command and compare the settled target
  task automatic tgt(input logic [8:0] c, input logic [17:0] t, input logic o);
    cmd_set <= c;
    repeat (5) @(posedge clk_i);
    check({13'h0, open_loop_o, target_o}, {13'h0, o, t});
  endtask : tgt
  // Bounded wait for a hall level
  task automatic wait_hall(input logic v);
    int k;
    k = 0;
    while (hall !== v) begin
      k++;
      if (k > 1000) begin
        num_errors++;
        $display("unexpected at %0t: hall timeout got %h expected %h", $time, hall, v);
        stop_test();
      end
      @(posedge clk_i);
    end
  endtask : wait_hall
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, fan_curve_pkg::OFS_CURVE0, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, fan_curve_pkg::OFS_CURVE0, 32'h2864);
    apb(1'b1, fan_curve_pkg::OFS_CURVE1, 32'h002B);
    apb(1'b1, fan_curve_pkg::OFS_CURVE2, 32'h3E83);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE1, 32'h0100);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE2, 32'h0200);
    apb(1'b0, fan_curve_pkg::OFS_CURVE2, 32'h0);
    check(rd, 32'h3E83);
    apb(1'b1, 12'h01C, 32'hFFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h01C, 32'h0);
    check(rd, 32'h0);
    tgt(9'h0C8, 18'h0044C, 1'b0);
    apb(1'b0, fan_curve_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'h7FFFF, 32'h4044C);
    tgt(9'h190, 18'h004B0, 1'b0);
    tgt(9'h05A, 18'h003E8, 1'b0);
    tgt(9'h050, 18'h00000, 1'b0);
    tgt(9'h05A, 18'h00000, 1'b0);
    tgt(9'h065, 18'h003E9, 1'b0);
    tgt(9'h000, 18'h00000, 1'b0);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE1, 32'h0101);
    tgt(9'h000, 18'h004B0, 1'b0);
    tgt(9'h014, 18'h00000, 1'b0);
    apb(1'b1, fan_curve_pkg::OFS_CURVE0, 32'hA864);
    tgt(9'h014, 18'h004B0, 1'b0);
    tgt(9'h05A, 18'h003E8, 1'b0);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE1, 32'h0100);
    tgt(9'h014, 18'h003E8, 1'b0);
    tgt(9'h000, 18'h003E8, 1'b0);
    apb(1'b1, fan_curve_pkg::OFS_CURVE0, 32'h2864);
    apb(1'b1, fan_curve_pkg::OFS_CURVE1, 32'h642B);
    tgt(9'h0FA, 18'h004B0, 1'b0);
    tgt(9'h0C8, 18'h0044C, 1'b0);
    apb(1'b1, fan_curve_pkg::OFS_CURVE1, 32'h002B);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE1, 32'h0102);
    tgt(9'h190, 18'h00190, 1'b1);
    tgt(9'h127, 18'h00127, 1'b1);
    tgt(9'h124, 18'h004A8, 1'b0);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE1, 32'h0103);
    tgt(9'h000, 18'h00200, 1'b1);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE1, 32'h0100);
    apb(1'b1, fan_curve_pkg::OFS_SLOPE2, 32'h0201);
    tgt(9'h0C8, 18'h00044, 1'b1);
    tgt(9'h190, 18'h0004A, 1'b1);
    tgt(9'h05A, 18'h0003E, 1'b1);
    run <= 1'b1;
    repeat (3000) @(posedge clk_i);
    wait_hall(1'b0);
    wait_hall(1'b1);
    repeat (100) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h0);
    wait_hall(1'b0);
    repeat (100) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h1);
    for (int i = 1; i < 7; i++) begin
      apb(1'b1, fan_curve_pkg::OFS_PULSE, {29'h0, 3'(i)});
      repeat (400) @(posedge clk_i);
      n = 0;
      prev = pin_oe;
      repeat (6000) begin
        @(posedge clk_i);
        if (pin_oe !== prev) n++;
        prev = pin_oe;
      end
      check({31'h0, n >= tog[i] - 2 && n <= tog[i] + 2}, 32'h1);
    end
    apb(1'b1, fan_curve_pkg::OFS_PULSE, 32'h8);
    lock_det <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h1);
    lock_det <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h0);
    apb(1'b1, fan_curve_pkg::OFS_PULSE, 32'h0);
    run <= 1'b0;
    repeat (1000) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h1);
    repeat (SLOW) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h0);
    stop_test();
  end
endmodule : testbench
bind fan_speed_curve fan_curve_assertions #(.SLOW_CYC(SLOW_CYC), .TGT_W(TGT_W)) u_fan_curve_assertions (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .speed_command_in_i(speed_command_in_i), .hall_i(hall_i),
  .lock_detect_i(lock_detect_i), .target_o(target_o), .open_loop_o(open_loop_o),
  .motor_en_o(motor_en_o), .rotation_pulse_out_o(rotation_pulse_out_o),
  .rotation_pulse_out_oe_o(rotation_pulse_out_oe_o));
